// [core/bmseq_top.v]
// Contract
// [RL1] descending move decrements source and destination index after each byte
// [RL2] ascending move increments source and destination index after each byte
// [RL3] count holds bytes minus one, decrements per byte, zero marks last byte
// [RL4] seven cycles per byte: fetch, two bank bytes, read, write, two internals
// [RL5] refetch same opcode until count done, then fetch at counter plus three
// [RL6] native wide mode: two fewer bytes and two fewer cycles
// [RL7] immediate data adds one or three bytes and cycles for 16/32 bit
// [RL8] direct page adds one cycle when direct low byte nonzero
// [RL9] abort point cycle; after it status and bank registers update
// [RL10] indexed page cross, write or wide index adds cycle; invalid when narrow
// [RL11] taken branch adds one cycle
// [RL12] emulation taken branch crossing page adds another cycle
// [RL13] marked cycles dropped in emulation mode
// [RL14] status bit clear and set ops add one cycle
// [RL15] on interrupt input, wait at cycle two for two cycles; code waits only for an edge at opcode fetch, not in native wide mode
// [RL16] read/write stays high throughout reset
// [RL17] both address strobes high only during opcode fetch
// [RL18] coprocessor may watch signature byte after break or coprocessor op
// [RL19] marked cycles add one when index registers are 32 bits
`include "bmseq_defs.vh"
module bmseq_top (
	// clock and reset
	input wire sys_clk,
	input wire rst_n,
	// start of a block move
	input wire start,
	input wire descending,
	input wire nativeWide,
	input wire [7:0] programBankIn,
	input wire [15:0] pcIn,
	input wire [15:0] countIn,
	input wire [15:0] srcIndexIn,
	input wire [15:0] dstIndexIn,
	// asynchronous pins
	input wire abortPin_n,
	input wire nmiPin_n,
	input wire irqPin_n,
	// memory data in
	input wire [7:0] dataIn,
	// adjustment inputs for the general cycle table
	input wire isImm,
	input wire imm16,
	input wire imm32,
	input wire isDirect,
	input wire [7:0] directRegLowByte,
	input wire isIndexed,
	input wire pageCross,
	input wire isWrite,
	input wire index16,
	input wire index32,
	input wire isBranch,
	input wire branchTaken,
	input wire emuMarked,
	input wire isStatusBitsOp,
	input wire idx32Marked,
	input wire emulationMode,
	// bus outputs
	output reg [23:0] addrOut,
	output reg [7:0] dataOut,
	output reg dataOe,
	output reg readWrite,
	output reg validDataAddrStrobe,
	output reg validProgramAddrStrobe,
	output wire instrSync,
	// status outputs
	output reg busy,
	output reg done,
	output reg aborted,
	output reg [15:0] countOut,
	output reg [15:0] srcIndexOut,
	output reg [15:0] dstIndexOut,
	output reg [15:0] pcOut,
	output reg [7:0] dataBankReg,
	output reg [7:0] programBankReg,
	output reg abortWindow,
	output reg [3:0] cyclesPerByte,
	output reg [3:0] insnBytes,
	output reg [3:0] extraCyclesOut,
	output reg [3:0] lessCyclesOut,
	output reg [3:0] extraBytesOut,
	output reg idxCycleInvalidOut
);
	localparam S_IDLE = 2'h0;
	localparam S_RUN = 2'h1;
	localparam S_WAIT = 2'h2;

	reg [1:0] state_reg;
	reg [2:0] phase_reg;
	reg [2:0] phase_next;
	reg [1:0] waitCnt_reg;
	reg descending_reg;
	reg nativeWide_reg;
	reg [7:0] destBankByte_reg;
	reg [7:0] srcBankByte_reg;
	reg [2:0] abortSync_reg;
	reg [2:0] nmiSync_reg;
	reg [2:0] irqSync_reg;
	wire abortReq;
	wire intEdge;
	wire [3:0] extraC;
	wire [3:0] lessC;
	wire [3:0] extraB;
	wire idxInv;

	function [15:0] stepIndex;
		input [15:0] idx;
		input down;
		begin
			stepIndex = down ? idx - 16'h0001 : idx + 16'h0001;
		end
	endfunction

	bmseq_adjust uAdjust (
		.isImm(isImm),
		.imm16(imm16),
		.imm32(imm32),
		.isDirect(isDirect),
		.directRegLowByte(directRegLowByte),
		.isIndexed(isIndexed),
		.pageCross(pageCross),
		.isWrite(isWrite),
		.index16(index16),
		.index32(index32),
		.isBranch(isBranch),
		.branchTaken(branchTaken),
		.emuMarked(emuMarked),
		.isStatusBitsOp(isStatusBitsOp),
		.idx32Marked(idx32Marked),
		.emulationMode(emulationMode),
		.extraCycles(extraC),
		.lessCycles(lessC),
		.extraBytes(extraB),
		.idxCycleInvalid(idxInv)
	);

	// pin synchronisers, stage 0 read only by stage 1
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			abortSync_reg <= 3'h7;
			nmiSync_reg <= 3'h7;
			irqSync_reg <= 3'h7;
		end else begin
			abortSync_reg <= {abortSync_reg[1:0], abortPin_n};
			nmiSync_reg <= {nmiSync_reg[1:0], nmiPin_n};
			irqSync_reg <= {irqSync_reg[1:0], irqPin_n};
		end
	end
	assign abortReq = ~abortSync_reg[1];
	assign intEdge = (nmiSync_reg[2] & ~nmiSync_reg[1]) | (irqSync_reg[2] & ~irqSync_reg[1]);

	// both strobes high marks opcode fetch
	assign instrSync = validDataAddrStrobe & validProgramAddrStrobe; // [RL17]

	// phase sequence; native wide skips the two bank-byte fetches
	always @* begin
		case (phase_reg)
			`BMSEQ_PH_OPC: phase_next = nativeWide_reg ? `BMSEQ_PH_RD : `BMSEQ_PH_DBK; // [RL6]
			`BMSEQ_PH_DBK: phase_next = `BMSEQ_PH_SBK;
			`BMSEQ_PH_SBK: phase_next = `BMSEQ_PH_RD;
			`BMSEQ_PH_RD: phase_next = `BMSEQ_PH_WR;
			`BMSEQ_PH_WR: phase_next = `BMSEQ_PH_IO1;
			`BMSEQ_PH_IO1: phase_next = `BMSEQ_PH_IO2;
			`BMSEQ_PH_IO2: phase_next = `BMSEQ_PH_OPC;
			default: phase_next = `BMSEQ_PH_IDLE;
		endcase
	end

	always @(posedge sys_clk) begin
		if (!rst_n) begin
			state_reg <= S_IDLE;
			phase_reg <= `BMSEQ_PH_IDLE;
			waitCnt_reg <= 2'h0;
			descending_reg <= 1'b0;
			nativeWide_reg <= 1'b0;
			destBankByte_reg <= 8'h00;
			srcBankByte_reg <= 8'h00;
			addrOut <= 24'h000000;
			dataOut <= 8'h00;
			dataOe <= 1'b0;
			readWrite <= 1'b1; // [RL16]
			validDataAddrStrobe <= 1'b0;
			validProgramAddrStrobe <= 1'b0;
			busy <= 1'b0;
			done <= 1'b0;
			aborted <= 1'b0;
			countOut <= 16'h0000;
			srcIndexOut <= 16'h0000;
			dstIndexOut <= 16'h0000;
			pcOut <= 16'h0000;
			dataBankReg <= 8'h00;
			programBankReg <= 8'h00;
			abortWindow <= 1'b0;
			cyclesPerByte <= `BMSEQ_CYC_PER_BYTE;
			insnBytes <= `BMSEQ_INSN_LEN;
			extraCyclesOut <= 4'h0;
			lessCyclesOut <= 4'h0;
			extraBytesOut <= 4'h0;
			idxCycleInvalidOut <= 1'b0;
		end else begin
			done <= 1'b0;
			abortWindow <= 1'b0;
			extraCyclesOut <= extraC;
			lessCyclesOut <= lessC;
			extraBytesOut <= extraB;
			idxCycleInvalidOut <= idxInv;
			case (state_reg)
				S_IDLE: begin
					readWrite <= 1'b1;
					dataOe <= 1'b0;
					validDataAddrStrobe <= 1'b0;
					validProgramAddrStrobe <= 1'b0;
					if (start) begin
						state_reg <= S_RUN;
						busy <= 1'b1;
						aborted <= 1'b0;
						descending_reg <= descending;
						nativeWide_reg <= nativeWide;
						programBankReg <= programBankIn;
						pcOut <= pcIn;
						countOut <= countIn; // [RL3]
						srcIndexOut <= srcIndexIn;
						dstIndexOut <= dstIndexIn;
						phase_reg <= `BMSEQ_PH_OPC;
						cyclesPerByte <= nativeWide ?
							`BMSEQ_CYC_PER_BYTE - `BMSEQ_NATIVE_SAVE : `BMSEQ_CYC_PER_BYTE; // [RL6]
						insnBytes <= nativeWide ?
							`BMSEQ_INSN_LEN - `BMSEQ_NATIVE_SAVE : `BMSEQ_INSN_LEN; // [RL6]
						// opcode fetch at program bank and counter
						addrOut <= {programBankIn, pcIn}; // [RL4]
						validDataAddrStrobe <= 1'b1;
						validProgramAddrStrobe <= 1'b1;
					end
				end
				S_WAIT: begin
					// hold in cycle two with strobes low
					validDataAddrStrobe <= 1'b0;
					validProgramAddrStrobe <= 1'b0;
					if ({2'h0, waitCnt_reg} == `BMSEQ_IRQ_WAIT - 4'h1) begin // [RL15]
						state_reg <= S_RUN;
						phase_reg <= `BMSEQ_PH_DBK;
						addrOut <= {programBankReg, pcOut + 16'h0001};
						validProgramAddrStrobe <= 1'b1;
					end
					waitCnt_reg <= waitCnt_reg + 2'h1;
				end
				S_RUN: begin
					phase_reg <= phase_next;
					dataOe <= 1'b0;
					readWrite <= 1'b1;
					validDataAddrStrobe <= 1'b0;
					validProgramAddrStrobe <= 1'b0;
					case (phase_reg)
						`BMSEQ_PH_OPC: begin
							if (intEdge && !nativeWide_reg) begin
								state_reg <= S_WAIT; // [RL15]
								waitCnt_reg <= 2'h0;
								phase_reg <= `BMSEQ_PH_OPC;
							end else if (nativeWide_reg) begin
								addrOut <= {srcBankByte_reg, srcIndexOut}; // [RL6]
								validDataAddrStrobe <= 1'b1;
							end else begin
								addrOut <= {programBankReg, pcOut + 16'h0001}; // [RL4]
								validProgramAddrStrobe <= 1'b1;
							end
						end
						`BMSEQ_PH_DBK: begin
							destBankByte_reg <= dataIn;
							addrOut <= {programBankReg, pcOut + 16'h0002}; // [RL4]
							validProgramAddrStrobe <= 1'b1;
						end
						`BMSEQ_PH_SBK: begin
							srcBankByte_reg <= dataIn;
							addrOut <= {dataIn, srcIndexOut}; // [RL4]
							validDataAddrStrobe <= 1'b1;
						end
						`BMSEQ_PH_RD: begin
							dataOut <= dataIn;
							addrOut <= {destBankByte_reg, dstIndexOut}; // [RL4]
							validDataAddrStrobe <= 1'b1;
							readWrite <= 1'b0;
							dataOe <= 1'b1;
						end
						`BMSEQ_PH_WR: begin
							// abort point: last cycle abortable
							abortWindow <= 1'b1; // [RL9]
							srcIndexOut <= stepIndex(srcIndexOut, descending_reg); // [RL1] [RL2]
							dstIndexOut <= stepIndex(dstIndexOut, descending_reg); // [RL1] [RL2]
							if (abortReq) begin
								aborted <= 1'b1; // [RL9]
								state_reg <= S_IDLE;
								busy <= 1'b0;
								phase_reg <= `BMSEQ_PH_IDLE;
							end else begin
								dataBankReg <= destBankByte_reg; // [RL9]
							end
							addrOut <= {destBankByte_reg, dstIndexOut}; // [RL4]
						end
						`BMSEQ_PH_IO1: begin
							// first internal cycle keeps the pre-step write address
							addrOut <= addrOut; // [RL4]
						end
						`BMSEQ_PH_IO2: begin
							countOut <= countOut - 16'h0001; // [RL3]
							validDataAddrStrobe <= 1'b1;
							validProgramAddrStrobe <= 1'b1;
							if (countOut == 16'h0000) begin
								// final byte: move on to next instruction
								pcOut <= pcOut + {12'h000, insnBytes}; // [RL5] [RL6]
								addrOut <= {programBankReg, pcOut + {12'h000, insnBytes}}; // [RL5] [RL6]
								state_reg <= S_IDLE;
								phase_reg <= `BMSEQ_PH_IDLE;
								busy <= 1'b0;
								done <= 1'b1;
							end else begin
								addrOut <= {programBankReg, pcOut}; // [RL5]
							end
						end
						default: begin
							state_reg <= S_IDLE;
						end
					endcase
				end
				default: begin
					state_reg <= S_IDLE;
				end
			endcase
		end
	end
endmodule

// [pkg/bmseq_defs.vh]
`ifndef BMSEQ_DEFS_VH
`define BMSEQ_DEFS_VH
// cycle phases of a block-move byte
`define BMSEQ_PH_OPC 3'h0
`define BMSEQ_PH_DBK 3'h1
`define BMSEQ_PH_SBK 3'h2
`define BMSEQ_PH_RD 3'h3
`define BMSEQ_PH_WR 3'h4
`define BMSEQ_PH_IO1 3'h5
`define BMSEQ_PH_IO2 3'h6
`define BMSEQ_PH_IDLE 3'h7
// cycles per byte and native-mode reduction
`define BMSEQ_CYC_PER_BYTE 4'h7
`define BMSEQ_NATIVE_SAVE 4'h2
// instruction length in bytes, and next-opcode step
`define BMSEQ_INSN_LEN 4'h3
`define BMSEQ_PC_STEP 16'h0003
// extra cycles / bytes
`define BMSEQ_IMM16_EXTRA 4'h1
`define BMSEQ_IMM32_EXTRA 4'h3
`define BMSEQ_ONE_EXTRA 4'h1
`define BMSEQ_IRQ_WAIT 4'h2
`endif

// [core/bmseq_adjust.v]
`include "bmseq_defs.vh"
module bmseq_adjust (
	// instruction class flags
	input wire isImm,
	input wire imm16,
	input wire imm32,
	input wire isDirect,
	input wire [7:0] directRegLowByte,
	input wire isIndexed,
	input wire pageCross,
	input wire isWrite,
	input wire index16,
	input wire index32,
	input wire isBranch,
	input wire branchTaken,
	input wire emuMarked,
	input wire isStatusBitsOp,
	input wire idx32Marked,
	input wire emulationMode,
	// results
	output wire [3:0] extraCycles,
	output wire [3:0] lessCycles,
	output wire [3:0] extraBytes,
	output wire idxCycleInvalid
);
	wire immC16 = isImm & imm16;
	wire immC32 = isImm & imm32;
	wire idxCyc = isIndexed & (pageCross | isWrite | index16 | index32);
	assign extraBytes = immC32 ? `BMSEQ_IMM32_EXTRA : (immC16 ? `BMSEQ_IMM16_EXTRA : 4'h0); // [RL7]
	assign extraCycles = (immC32 ? `BMSEQ_IMM32_EXTRA : (immC16 ? `BMSEQ_IMM16_EXTRA : 4'h0)) // [RL7]
		+ {3'h0, isDirect & (directRegLowByte != 8'h00)} // [RL8]
		+ {3'h0, idxCyc} // [RL10]
		+ {3'h0, isBranch & branchTaken} // [RL11]
		+ {3'h0, isBranch & branchTaken & pageCross & emulationMode} // [RL12]
		+ {3'h0, isStatusBitsOp} // [RL14]
		+ {3'h0, idx32Marked & index32}; // [RL19]
	assign lessCycles = {3'h0, emuMarked & emulationMode}; // [RL13]
	assign idxCycleInvalid = idxCyc & (emulationMode | ~(index16 | index32)); // [RL10]
endmodule

// [tb/bmseq_checker.sv]
module bmseq_checker (
	// clock and reset
	input wire sys_clk,
	input wire rst_n,
	// control and qualifiers
	input wire nativeWide,
	input wire nmiPin_n,
	input wire irqPin_n,
	input wire [7:0] directRegLowByte,
	input wire isImm,
	input wire imm16,
	input wire imm32,
	input wire isDirect,
	input wire isIndexed,
	input wire pageCross,
	input wire isWrite,
	input wire index16,
	input wire index32,
	input wire isBranch,
	input wire branchTaken,
	input wire emuMarked,
	input wire isStatusBitsOp,
	input wire idx32Marked,
	input wire emulationMode,
	// outputs watched
	input wire readWrite,
	input wire validDataAddrStrobe,
	input wire validProgramAddrStrobe,
	input wire instrSync,
	input wire dataOe,
	input wire busy,
	input wire done,
	input wire aborted,
	input wire [3:0] cyclesPerByte,
	input wire [3:0] insnBytes,
	input wire [3:0] extraCyclesOut,
	input wire [3:0] lessCyclesOut,
	input wire [3:0] extraBytesOut
);
	timeunit 1ns;
	timeprecision 1ns;
	wire [5:0] cls = {isImm, isDirect, isIndexed, isBranch, isStatusBitsOp, idx32Marked};
	reg [3:0] calm;
	// a recent interrupt edge may legally stretch the walk
	always @(posedge sys_clk)
		if (!rst_n || !nmiPin_n || !irqPin_n)
			calm <= 4'h0;
		else if (calm != 4'hF)
			calm <= calm + 4'h1;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	sync_fetch_a: assert property (
		instrSync == (validDataAddrStrobe && validProgramAddrStrobe) && (!instrSync || readWrite))
		else $error("sync strobe mismatch");
	reset_read_a: assert property (disable iff (1'h0) !rst_n |=> readWrite)
		else $error("write seen in reset");
	write_cycle_a: assert property (
		!readWrite |-> dataOe && validDataAddrStrobe && !validProgramAddrStrobe)
		else $error("write cycle strobes wrong");
	byte_walk_a: assert property (disable iff (!rst_n || aborted)
		instrSync && !done && !nativeWide && calm > 4'h7 |=>
		(validProgramAddrStrobe && !validDataAddrStrobe)[*2] ##1
		(validDataAddrStrobe && readWrite) ##1 !readWrite ##1
		(!validDataAddrStrobe && !validProgramAddrStrobe && readWrite)[*2])
		else $error("byte cycle order wrong");
	done_fetch_a: assert property (done && !aborted |-> instrSync)
		else $error("done without fetch");
	cycle_len_a: assert property (
		busy && $past(busy) && $stable(nativeWide) |->
		cyclesPerByte == (nativeWide ? 4'h5 : 4'h7) && insnBytes == (nativeWide ? 4'h1 : 4'h3))
		else $error("byte length wrong");
	imm_extra_a: assert property (cls == 6'h20 |=>
		extraBytesOut == ($past(imm32) ? 4'h3 : {3'h0, $past(imm16)}) &&
		extraCyclesOut == extraBytesOut)
		else $error("immediate extra wrong");
	direct_extra_a: assert property (cls == 6'h10 |=>
		extraCyclesOut == {3'h0, $past(directRegLowByte != 8'h00)})
		else $error("direct extra wrong");
	index_extra_a: assert property (cls == 6'h08 |=>
		extraCyclesOut == {3'h0, $past(pageCross || isWrite || index16 || index32)})
		else $error("index extra wrong");
	branch_extra_a: assert property (cls == 6'h04 |=>
		extraCyclesOut == {3'h0, $past(branchTaken)} +
		{3'h0, $past(branchTaken && pageCross && emulationMode)})
		else $error("branch extra wrong");
	emu_less_a: assert property (1'h1 |=>
		lessCyclesOut == {3'h0, $past(emuMarked && emulationMode)})
		else $error("emulation saving wrong");
	status_extra_a: assert property (cls == 6'h02 |=> extraCyclesOut == 4'h1)
		else $error("status op extra wrong");
endmodule

bind bmseq_top bmseq_checker u_bmseq_checker (.*);

// [tb/bmseq_mem.sv]
module bmseq_mem (
	// bus from the sequencer
	input wire sys_clk,
	input wire [23:0] addrOut,
	input wire readWrite,
	input wire validDataAddrStrobe,
	input wire validProgramAddrStrobe,
	// read data
	output reg [7:0] dataIn
);
	timeunit 1ns;
	timeprecision 1ns;
	reg churn = 1'h0;
	// idle bus flips every cycle so stale data never looks valid
	always @(posedge sys_clk)
		churn <= ~churn;
	always @*
		if (readWrite && (validDataAddrStrobe || validProgramAddrStrobe))
			dataIn = addrOut[7:0] ^ addrOut[15:8] ^ addrOut[23:16] ^ 8'hA5;
		else
			dataIn = {8{churn}};
endmodule

// [tb/testbench.sv]
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	reg sys_clk = 1'h0, rst_n = 1'h0, start = 1'h0, descending = 1'h0, nativeWide = 1'h0;
	reg abortPin_n = 1'h1, nmiPin_n = 1'h1, irqPin_n = 1'h1;
	reg [7:0] programBankIn = 8'h12, directRegLowByte = 8'h00, sb, db;
	reg [15:0] pcIn = 16'h1000, countIn = 16'h0, srcIndexIn = 16'h0, dstIndexIn = 16'h0;
	reg isImm = 1'h0, imm16 = 1'h0, imm32 = 1'h0, isDirect = 1'h0, isIndexed = 1'h0;
	reg pageCross = 1'h0, isWrite = 1'h0, index16 = 1'h0, index32 = 1'h0, isBranch = 1'h0;
	reg branchTaken = 1'h0, emuMarked = 1'h0, isStatusBitsOp = 1'h0, idx32Marked = 1'h0;
	reg emulationMode = 1'h0;
	wire [23:0] addrOut;
	wire [15:0] countOut, srcIndexOut, dstIndexOut, pcOut;
	wire [7:0] dataIn, dataOut, dataBankReg, programBankReg;
	wire [3:0] cyclesPerByte, insnBytes, extraCyclesOut, lessCyclesOut, extraBytesOut;
	wire dataOe, readWrite, validDataAddrStrobe, validProgramAddrStrobe, instrSync;
	wire busy, done, aborted, abortWindow, idxCycleInvalidOut;
	integer num_errors = 0, n_checks = 0;
	bmseq_top u_bmseq_top (.*);
	bmseq_mem u_bmseq_mem (.*);
	always #25 sys_clk = ~sys_clk;
	function [7:0] mem(input [23:0] a);
		mem = a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'hA5;
	endfunction
	task chk(input [31:0] seen, input [31:0] exp);
		begin
			n_checks = n_checks + 1;
			if (seen !== exp) begin
				num_errors = num_errors + 1;
				$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task finish_test;
		begin
			$display("checks %0d errors %0d", n_checks, num_errors);
			if (num_errors == 0 && n_checks > 0)
				$display("ALL CHECKS OK");
			else
				$display("CHECKS NOT OK");
			$finish;
		end
	endtask
	task hang;
		begin
			num_errors = num_errors + 1;
			finish_test;
		end
	endtask
	task tick;
		begin
			@(posedge sys_clk);
			#1;
		end
	endtask
	task kick;
		integer i;
		begin
			start = 1'h1;
			tick;
			start = 1'h0;
			for (i = 0; instrSync !== 1'h1; i = i + 1) begin
				if (i > 6)
					hang;
				tick;
			end
		end
	endtask
	task move(input desc, input nat, input [15:0] cnt, input [15:0] x0, input [15:0] y0);
		reg [15:0] x, y;
		reg [23:0] a;
		reg [2:0] s;
		integer k, p, n;
		begin
			descending = desc;
			nativeWide = nat;
			countIn = cnt;
			srcIndexIn = x0;
			dstIndexIn = y0;
			// wide mode reuses banks fetched by the last normal run
			if (!nat) begin
				db = mem({programBankIn, pcIn + 16'h1});
				sb = mem({programBankIn, pcIn + 16'h2});
			end
			n = nat ? 5 : 7;
			kick;
			for (k = 0; k <= cnt; k = k + 1)
				for (p = 0; p < n; p = p + 1) begin
					x = desc ? x0 - k[15:0] : x0 + k[15:0];
					y = desc ? y0 - k[15:0] : y0 + k[15:0];
					a = {programBankIn, pcIn + p[15:0]};
					s = (p == 0) ? 3'h7 : 3'h3;
					if (p == n - 4) begin
						a = {sb, x};
						s = 3'h5;
					end else if (p > n - 4) begin
						a = {db, y};
						s = (p == n - 3) ? 3'h4 : 3'h1;
					end
					chk(addrOut, a);
					chk({validDataAddrStrobe, validProgramAddrStrobe, readWrite}, s);
					if (s == 3'h4)
						chk(dataOut, mem({sb, x}));
					// a start while busy must be ignored
					if (k == 0 && p == 2)
						start = 1'h1;
					if (k == 0 && p == 3)
						start = 1'h0;
					tick;
				end
			a = {programBankIn, pcIn + (nat ? 16'h1 : 16'h3)};
			x = desc ? x0 - cnt - 16'h1 : x0 + cnt + 16'h1;
			y = desc ? y0 - cnt - 16'h1 : y0 + cnt + 16'h1;
			chk(addrOut, a);
			chk(pcOut, a[15:0]);
			chk(done, 1'h1);
			chk(countOut, 16'hFFFF);
			chk(srcIndexOut, x);
			chk(dstIndexOut, y);
			chk(insnBytes, nat ? 4'h1 : 4'h3);
			chk(dataBankReg, db);
			chk(programBankReg, programBankIn);
		end
	endtask
	task irq_wait;
		integer i;
		begin
			countIn = 16'h1;
			kick;
			repeat (5) tick;
			irqPin_n = 1'h0;
			for (i = 5; done !== 1'h1; i = i + 1) begin
				if (i > 30)
					hang;
				tick;
			end
			chk(i, 32'h10);
			irqPin_n = 1'h1;
		end
	endtask
	task abort_run;
		integer i;
		begin
			abortPin_n = 1'h0;
			kick;
			for (i = 0; aborted !== 1'h1; i = i + 1) begin
				if (i > 12)
					hang;
				tick;
			end
			chk(abortWindow, 1'h1);
			tick;
			chk(busy, 1'h0);
			chk(abortWindow, 1'h0);
			abortPin_n = 1'h1;
		end
	endtask
	task reset_mid;
		begin
			countIn = 16'h3;
			kick;
			repeat (3) tick;
			rst_n = 1'h0;
			repeat (3) tick;
			chk(readWrite, 1'h1);
			chk(busy, 1'h0);
			rst_n = 1'h1;
		end
	endtask
	task adj(input [14:0] q, input [7:0] dl, input [3:0] ec, input [3:0] eb);
		begin
			{isImm, imm16, imm32, isDirect, isIndexed, pageCross, isWrite, index16, index32,
				isBranch, branchTaken, emuMarked, isStatusBitsOp, idx32Marked, emulationMode} = q;
			directRegLowByte = dl;
			repeat (2) tick;
			chk(extraCyclesOut, ec);
			chk(extraBytesOut, eb);
			chk(lessCyclesOut, {3'h0, q[3] & q[0]});
			chk(idxCycleInvalidOut, q[10] & (q[9] | q[8] | q[7] | q[6]) & (q[0] | ~(q[7] | q[6])));
		end
	endtask
	initial begin
		repeat (3) tick;
		chk(readWrite, 1'h1);
		rst_n = 1'h1;
		move(1'h0, 1'h0, 16'h2, 16'h0100, 16'h0200);
		move(1'h1, 1'h0, 16'h1, 16'h0000, 16'h0001);
		move(1'h0, 1'h1, 16'h1, 16'hFFFF, 16'h0300);
		move(1'h1, 1'h1, 16'h0, 16'h0040, 16'h0080);
		nativeWide = 1'h0;
		irq_wait;
		abort_run;
		reset_mid;
		adj(15'h6000, 8'h00, 4'h1, 4'h1);
		adj(15'h5000, 8'h00, 4'h3, 4'h3);
		adj(15'h0800, 8'h00, 4'h0, 4'h0);
		adj(15'h0800, 8'h01, 4'h1, 4'h0);
		adj(15'h0600, 8'h00, 4'h1, 4'h0);
		adj(15'h0400, 8'h00, 4'h0, 4'h0);
		adj(15'h0480, 8'h00, 4'h1, 4'h0);
		adj(15'h0020, 8'h00, 4'h0, 4'h0);
		adj(15'h0030, 8'h00, 4'h1, 4'h0);
		adj(15'h0231, 8'h00, 4'h2, 4'h0);
		adj(15'h0004, 8'h00, 4'h1, 4'h0);
		adj(15'h0009, 8'h00, 4'h0, 4'h0);
		adj(15'h0042, 8'h00, 4'h1, 4'h0);
		finish_test;
	end
endmodule
